/* pix_gen.sv */
// line-locked pixel clock generator with hold (free-run) support
`timescale 1ns/1ps
module pix_gen #(
	parameter int DW = sync_coast_pkg::DIV_W,
	parameter int PW = sync_coast_pkg::PER_W
) (
	input  wire logic          clk_i,
	input  wire logic          arst_n_i,
	input  wire logic          edge_i,
	input  wire logic          coast_i,
	input  wire logic [DW-1:0] div_i,
	output logic               pix_o,
	output logic               line_o,
	output logic               locked_o
);
	logic [DW-1:0] div_hold_r;
	logic [DW-1:0] ph_r;
	logic [PW-1:0] cnt_r;
	logic [PW-1:0] per_r;
	logic          track;

	// elaboration check: the phase and period counters need at least these widths
	if (DW < 2 || PW < 4)
	begin : g_width_check
		$error("pix_gen widths too small");
	end

	// hold blocks tracking; edges seen during hold are dropped
	assign track = edge_i && !coast_i;

	// rate is frozen at the value held when hold began
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
			div_hold_r <= DW'(sync_coast_pkg::DIV_RST);
		else if (!coast_i)
			div_hold_r <= div_i;

	// half-period counter, realigned to each tracked edge
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			ph_r  <= '0;
			pix_o <= 1'b0;
		end
		else if (track)
		begin
			ph_r  <= '0;
			pix_o <= 1'b1;
		end
		else if (ph_r >= div_hold_r - DW'(1))
		begin
			ph_r  <= '0;
			pix_o <= ~pix_o;
		end
		else
			ph_r <= ph_r + DW'(1);

	// line period measure; while holding, line starts are predicted from it
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			cnt_r    <= '0;
			per_r    <= '0;
			line_o   <= 1'b0;
			locked_o <= 1'b0;
		end
		else if (track)
		begin
			per_r    <= cnt_r + PW'(1);
			cnt_r    <= '0;
			line_o   <= 1'b1;
			locked_o <= 1'b1;
		end
		else if (coast_i && locked_o && cnt_r + PW'(1) >= per_r)
		begin
			cnt_r  <= '0;
			line_o <= 1'b1;
		end
		else
		begin
			line_o <= 1'b0;
			if (~&cnt_r)
				cnt_r <= cnt_r + PW'(1); // saturate on a lost sync
		end

	a_hold_rate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		coast_i |=> $stable(div_hold_r))
		else $error("rate changed during hold");
	a_hold_phase: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		coast_i && edge_i && ph_r + DW'(1) < div_hold_r |=> ph_r == $past(ph_r) + DW'(1))
		else $error("phase realigned during hold");
endmodule

/* sync_coast_ctrl.sv */
// sync conditioning, hold and pixel clock source control with wishbone registers
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module sync_coast_ctrl (
	input  wire logic        CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	input  wire logic        HORIZ_SYNC_IN_A_I,
	input  wire logic        EXT_CLOCK_OR_HOLD_PIN_I,
	input  wire logic        GREEN_SYNC_CMP_I,
	input  wire logic        SLEEP_TRISTATE_PIN_I,
	output logic             PIXEL_CLK_O,
	output logic             REGEN_HSYNC_O,
	output logic             SLICER_OUT_O,
	output logic      [5:0]  SOG_THRESH_O,
	output logic             POWER_DOWN_O,
	output logic             OUT_TRISTATE_O,
	output logic             COASTING_O
);
	localparam int TW = sync_coast_pkg::THR_W;
	localparam int DW = sync_coast_pkg::DIV_W;

	logic [3:0]    sync1_r;
	logic [3:0]    sync2_r;
	logic          hs_s, pin_s, sog_s, slp_s;
	logic          hs_d_r;
	logic          lead_edge;
	logic [sync_coast_pkg::FILT_LEN-1:0] filt_sh_r;
	logic          hs_filt_r;
	logic [1:0]    hs_cfg_r, coast_cfg_r, slice_cfg_r, sleep_cfg_r;
	logic          ext_sel_r;
	logic [DW-1:0] div_r;
	logic          coast_act;
	logic          wr, rd_ok;
	logic [5:0]    idx;
	logic [31:0]   rd_nxt;
	logic          gen_pix, gen_line, gen_locked;
	logic          slice_nxt, sleep_act;
	logic          wrote_coast_r, wrote_thr_r;
	logic [31:0]   wr_word;

	// byte-lane merge for partial writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		return res;
	endfunction

	// pins cross into the clock domain through two flops; only stage two is read
	always_ff @(posedge CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
		begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end
		else
		begin
			sync1_r <= {SLEEP_TRISTATE_PIN_I, GREEN_SYNC_CMP_I,
				EXT_CLOCK_OR_HOLD_PIN_I, HORIZ_SYNC_IN_A_I};
			sync2_r <= sync1_r;
		end

	assign hs_s  = sync2_r[0];
	assign pin_s = sync2_r[1];
	assign sog_s = sync2_r[2];
	assign slp_s = sync2_r[3];

	// leading edge only; trailing edge is ignored
	always_ff @(posedge CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
			hs_d_r <= 1'b0;
		else
			hs_d_r <= hs_s;
	assign lead_edge = hs_cfg_r[0] ? (hs_s && !hs_d_r) : (!hs_s && hs_d_r);

	// glitch filter: level changes only after all samples agree
	always_ff @(posedge CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
		begin
			filt_sh_r <= '0;
			hs_filt_r <= 1'b0;
		end
		else
		begin
			filt_sh_r <= {filt_sh_r[sync_coast_pkg::FILT_LEN-2:0], hs_s};
			if (&filt_sh_r)
				hs_filt_r <= 1'b1;
			else if (~|filt_sh_r)
				hs_filt_r <= 1'b0;
		end

	// hold sense from the polarity bit; bit 6 forces hold from software.
	// the hold path reads the pin whatever the clock source is
	assign coast_act = coast_cfg_r[1] || (pin_s == coast_cfg_r[0]);

	pix_gen #(
		.DW (DW),
		.PW (sync_coast_pkg::PER_W)
	) u_gen (
		.clk_i    (CLK_I),
		.arst_n_i (ARST_N_I),
		.edge_i   (lead_edge),
		.coast_i  (coast_act),
		.div_i    (div_r),
		.pix_o    (gen_pix),
		.line_o   (gen_line),
		.locked_o (gen_locked)
	);

	// slicer source select
	always_comb
		unique case (slice_cfg_r)
			sync_coast_pkg::SEL_RAW_SOG: slice_nxt = sog_s;
			sync_coast_pkg::SEL_RAW_HS:  slice_nxt = hs_s;
			sync_coast_pkg::SEL_REGEN:   slice_nxt = gen_line;
			sync_coast_pkg::SEL_FILT:    slice_nxt = hs_filt_r;
		endcase

	// bit 2 gives the pin sense: 1 active high, 0 active low
	assign sleep_act = (slp_s == sleep_cfg_r[1]);

	// registered outputs; external clock only replaces the generated one
	always_ff @(posedge CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
		begin
			PIXEL_CLK_O    <= 1'b0;
			REGEN_HSYNC_O  <= 1'b0;
			SLICER_OUT_O   <= 1'b0;
			POWER_DOWN_O   <= 1'b0;
			OUT_TRISTATE_O <= 1'b0;
			COASTING_O     <= 1'b0;
		end
		else
		begin
			PIXEL_CLK_O    <= ext_sel_r ? pin_s : gen_pix;
			REGEN_HSYNC_O  <= gen_line;
			SLICER_OUT_O   <= slice_nxt;
			POWER_DOWN_O   <= sleep_act && !sleep_cfg_r[0];
			OUT_TRISTATE_O <= sleep_act && sleep_cfg_r[0];
			COASTING_O     <= coast_act;
		end

	// wishbone decode: single-cycle ack, dropped the cycle after
	assign idx = ADR_I[7:2];
	assign wr  = CYC_I && STB_I && WE_I && !ACK_O;
	// unselected byte lanes keep the current register contents
	assign wr_word = lane_merge(rd_nxt, DAT_I, SEL_I);

	// configuration writes; other addresses ignore writes
	always_ff @(posedge CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
		begin
			hs_cfg_r      <= sync_coast_pkg::HS_RST;
			coast_cfg_r   <= sync_coast_pkg::COAST_RST;
			slice_cfg_r   <= sync_coast_pkg::SLICE_RST;
			sleep_cfg_r   <= sync_coast_pkg::SLEEP_RST;
			ext_sel_r     <= 1'b0;
			div_r         <= sync_coast_pkg::DIV_RST;
			SOG_THRESH_O  <= sync_coast_pkg::THR_DEF;
			wrote_coast_r <= 1'b0;
			wrote_thr_r   <= 1'b0;
		end
		else if (wr)
		begin
			unique case (idx)
				sync_coast_pkg::IDX_HSYNC:
					hs_cfg_r <= wr_word[sync_coast_pkg::HS_LSB +: 2];
				sync_coast_pkg::IDX_COAST:
				begin
					coast_cfg_r   <= wr_word[sync_coast_pkg::COAST_LSB +: 2];
					wrote_coast_r <= 1'b1;
				end
				sync_coast_pkg::IDX_SLICE:
					slice_cfg_r <= wr_word[sync_coast_pkg::SLICE_LSB +: 2];
				sync_coast_pkg::IDX_SLEEP:
					sleep_cfg_r <= wr_word[sync_coast_pkg::SLEEP_LSB +: 2];
				sync_coast_pkg::IDX_CLKCFG:
				begin
					ext_sel_r <= wr_word[sync_coast_pkg::EXT_BIT];
					if (wr_word[sync_coast_pkg::DIV_LSB +: DW] != '0)
						div_r <= wr_word[sync_coast_pkg::DIV_LSB +: DW];
				end
				sync_coast_pkg::IDX_THRESH:
				begin
					wrote_thr_r <= 1'b1;
					if (wr_word[TW-1:0] >= sync_coast_pkg::THR_MIN
						&& wr_word[TW-1:0] <= sync_coast_pkg::THR_MAX)
						SOG_THRESH_O <= wr_word[TW-1:0];
				end
				default: ;
			endcase
		end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_nxt = 32'h0;
		rd_ok  = 1'b1;
		unique case (idx)
			sync_coast_pkg::IDX_HSYNC:  rd_nxt[sync_coast_pkg::HS_LSB +: 2]    = hs_cfg_r;
			sync_coast_pkg::IDX_COAST:  rd_nxt[sync_coast_pkg::COAST_LSB +: 2] = coast_cfg_r;
			sync_coast_pkg::IDX_SLICE:  rd_nxt[sync_coast_pkg::SLICE_LSB +: 2] = slice_cfg_r;
			sync_coast_pkg::IDX_SLEEP:  rd_nxt[sync_coast_pkg::SLEEP_LSB +: 2] = sleep_cfg_r;
			sync_coast_pkg::IDX_CLKCFG:
			begin
				rd_nxt[sync_coast_pkg::EXT_BIT]       = ext_sel_r;
				rd_nxt[sync_coast_pkg::DIV_LSB +: DW] = div_r;
			end
			sync_coast_pkg::IDX_THRESH: rd_nxt[TW-1:0] = SOG_THRESH_O;
			sync_coast_pkg::IDX_STATUS: rd_nxt[3:0] = {hs_filt_r, gen_locked,
				ext_sel_r, coast_act};
			default: rd_ok = 1'b0;
		endcase
	end

	// ack and read data are both registered
	always_ff @(posedge CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
		begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0;
		end
		else
		begin
			ACK_O <= CYC_I && STB_I && !ACK_O;
			DAT_O <= (CYC_I && STB_I && !WE_I && !ACK_O && rd_ok) ? rd_nxt : 32'h0;
		end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);

	a_coast_sense: assert property (!coast_cfg_r[1] && pin_s == coast_cfg_r[0]
		|=> COASTING_O)
		else $error("hold not seen at programmed sense");
	a_coast_default: assert property (!wrote_coast_r |->
		coast_cfg_r == sync_coast_pkg::COAST_RST)
		else $error("hold polarity lost its power-up value");
	a_thr_range: assert property (SOG_THRESH_O >= sync_coast_pkg::THR_MIN
		&& SOG_THRESH_O <= sync_coast_pkg::THR_MAX)
		else $error("threshold code out of range");
	a_thr_default: assert property (!wrote_thr_r |->
		SOG_THRESH_O == sync_coast_pkg::THR_DEF)
		else $error("threshold default wrong");
	a_slicer_raw: assert property (slice_cfg_r == sync_coast_pkg::SEL_RAW_SOG
		&& $stable(slice_cfg_r) |=> SLICER_OUT_O == $past(sog_s))
		else $error("slicer output not the raw green sync");
	a_ext_pass: assert property (ext_sel_r |=> PIXEL_CLK_O == $past(pin_s))
		else $error("external clock not passed");
	a_coast_indep: assert property ($stable(pin_s) && $stable(coast_cfg_r)
		&& $changed(ext_sel_r) |=> $stable(COASTING_O))
		else $error("clock source disturbed hold");
	a_sleep_role: assert property (sleep_cfg_r[0] |=> !POWER_DOWN_O)
		else $error("power-down in three-state role");
	a_lead_edge: assert property (hs_cfg_r[0] && $rose(hs_s) |-> lead_edge)
		else $error("rising edge missed");
	a_slice_hs: assert property (slice_cfg_r == sync_coast_pkg::SEL_RAW_HS
		&& $stable(slice_cfg_r) |=> SLICER_OUT_O == $past(hs_s))
		else $error("slicer output not raw sync");
	a_bus_ack: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
		else $error("ack not single cycle");

	c_hold_edge: cover property (coast_act && lead_edge);
	c_ext_clock: cover property (ext_sel_r && $rose(PIXEL_CLK_O));
	c_predicted: cover property (coast_act && gen_line);
	c_write_ack: cover property (wr ##1 ACK_O);
endmodule

/* sync_coast_ctrl_tb.sv */
// self-checking bench for the sync, hold and pixel clock control block
`timescale 1ns/1ps
module sync_coast_ctrl_tb;
	logic        clk      = 1'b0;
	logic        arst_n   = 1'b0;
	logic        cyc      = 1'b0;
	logic        we       = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [3:0]  sel      = 4'hf;
	logic [31:0] wdat     = 32'h0;
	logic        hold_pin = 1'b0; // grounded; hold polarity is 1 out of reset
	logic        green    = 1'b0;
	logic        sleep    = 1'b0;
	logic        run      = 1'b0;
	logic        idle     = 1'b0;
	logic        hsync;
	logic [31:0] rdat;
	logic [31:0] dat_o;
	logic        ack, pix, regen, slicer, pd, ts, coasting;
	logic [5:0]  thr;
	int          num_errors   = 0;
	int          total_checks = 0;

	always #4 clk = ~clk;

	sync_src_model sync_src_model_i (.clk_i(clk), .run_i(run), .idle_i(idle), .hsync_o(hsync));

	sync_coast_ctrl sync_coast_ctrl_i (
		.CLK_I(clk), .ARST_N_I(arst_n), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr),
		.SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .HORIZ_SYNC_IN_A_I(hsync),
		.EXT_CLOCK_OR_HOLD_PIN_I(hold_pin), .GREEN_SYNC_CMP_I(green),
		.SLEEP_TRISTATE_PIN_I(sleep), .PIXEL_CLK_O(pix), .REGEN_HSYNC_O(regen),
		.SLICER_OUT_O(slicer), .SOG_THRESH_O(thr), .POWER_DOWN_O(pd),
		.OUT_TRISTATE_O(ts), .COASTING_O(coasting));

	task automatic results;
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// a wait that used up its bound ends the run at once
	task automatic tmo(input int n, input int lim);
		if (n >= lim)
		begin
			num_errors++;
			results();
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	// classic cycle: hold everything until ack is seen, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n = 0;
		@(posedge clk);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		cyc  <= 1'b0;
		tmo(n, 50);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hf);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hf);
		chk(rdat, exp);
	endtask

	task automatic t_reset;
		chk(thr, 32'h0f);
		rchk(8'hc4, 32'h0000000f);
		rchk(8'h60, 32'h00000020);
		rchk(8'h48, 32'h0);
		rchk(8'h74, 32'h0);
		rchk(8'h98, 32'h0);
		rchk(8'h00, 32'h0);
	endtask

	// codes outside 1..33 and writes without the low lane keep the old code
	task automatic t_thresh;
		wr(8'hc4, 32'h01);
		chk(thr, 32'h01);
		wr(8'hc4, 32'h21);
		chk(thr, 32'h21);
		wr(8'hc4, 32'h00);
		chk(thr, 32'h21);
		wr(8'hc4, 32'h22);
		chk(thr, 32'h21);
		wb(1'b1, 8'hc4, 32'h05, 4'he);
		chk(thr, 32'h21);
		wr(8'hc4, 32'h0f);
	endtask

	task automatic t_slicer;
		for (int s = 3; s >= 0; s--)
		begin
			wr(8'h74, 32'(s));
			rchk(8'h74, 32'(s));
		end
		green <= 1'b1;
		ticks(5);
		chk(slicer, 32'h1);
		green <= 1'b0;
		ticks(5);
		chk(slicer, 32'h0);
		wr(8'h74, 32'h1);
		idle <= 1'b1;
		ticks(5);
		chk(slicer, 32'h1);
		idle <= 1'b0;
		ticks(5);
		chk(slicer, 32'h0);
		wr(8'h74, 32'h3);
		idle <= 1'b1;
		ticks(6);
		chk(slicer, 32'h0);
		ticks(4);
		chk(slicer, 32'h1);
		idle <= 1'b0;
		ticks(10);
		chk(slicer, 32'h0);
	endtask

	task automatic hold_case(input logic [31:0] cfg, input logic pin, input logic exp);
		wr(8'h60, cfg);
		hold_pin <= pin;
		ticks(6);
		chk(coasting, {31'h0, exp});
	endtask

	task automatic edge_case(input logic pol, input logic lvl, input logic exp);
		logic seen = 1'b0;
		wr(8'h48, {27'h0, pol, 4'h0});
		idle <= lvl;
		repeat (10)
		begin
			@(posedge clk);
			seen |= regen;
		end
		chk(seen, {31'h0, exp});
	endtask

	// cycles from one line pulse to the next
	task automatic gap(output int g);
		g = 0;
		while (regen !== 1'b1 && g < 200)
		begin
			@(posedge clk);
			g++;
		end
		g = 0;
		do
		begin
			@(posedge clk);
			g++;
		end
		while (regen !== 1'b1 && g < 200);
		tmo(g, 200);
	endtask

	// lock on a 40-cycle line, then hold while the source goes silent
	task automatic t_coast;
		int n = 0;
		int g;
		int p = 0;
		logic last;
		run <= 1'b1;
		do
		begin
			wb(1'b0, 8'hc8, 32'h0, 4'hf);
			n++;
		end
		while (rdat[2] !== 1'b1 && n < 200);
		tmo(n, 200);
		gap(g);
		chk(g, 32'd40);
		wr(8'h60, 32'h60);
		run <= 1'b0;
		gap(g);
		chk(g, 32'd40);
		chk(coasting, 32'h1);
		// free-running pixel clock keeps its rate: half period of 4 gives 5 rises in 40
		@(posedge clk);
		last = pix;
		repeat (40)
		begin
			@(posedge clk);
			if (pix === 1'b1 && last === 1'b0)
				p++;
			last = pix;
		end
		chk(p, 32'd5);
		wr(8'h60, 32'h20);
	endtask

	// pin drives the pixel clock three flops later; hold reads the same pin
	task automatic t_ext;
		wr(8'hc0, 32'h00000401);
		ticks(5);
		chk(pix, 32'h0);
		hold_pin <= 1'b1;
		ticks(3);
		chk(pix, 32'h0);
		ticks(1);
		chk(pix, 32'h1);
		ticks(2);
		chk(coasting, 32'h1);
		wb(1'b0, 8'hc8, 32'h0, 4'hf);
		chk(rdat & 32'h2, 32'h2);
		wr(8'h60, 32'h60);
		hold_pin <= 1'b0;
		wr(8'hc0, 32'h00000400);
		ticks(6);
		chk(coasting, 32'h1);
		wr(8'h60, 32'h20);
	endtask

	// a second reset mid-run brings back the power-up settings
	task automatic t_rereset;
		wr(8'hc4, 32'h05);
		wr(8'h60, 32'h00);
		arst_n <= 1'b0;
		ticks(2);
		chk(thr, 32'h0f);
		chk(coasting, 32'h0);
		arst_n <= 1'b1;
		rchk(8'h60, 32'h00000020);
		rchk(8'hc4, 32'h0000000f);
	endtask

	task automatic sleep_case(input logic [31:0] cfg, input logic pin, input logic [1:0] exp);
		wr(8'h98, cfg);
		sleep <= pin;
		ticks(5);
		chk({pd, ts}, {30'h0, exp});
	endtask

	initial
	begin
		ticks(20);
		arst_n <= 1'b1;
		t_reset();
		t_thresh();
		t_slicer();
		hold_case(32'h20, 1'b0, 1'b0);
		hold_case(32'h20, 1'b1, 1'b1);
		hold_case(32'h00, 1'b1, 1'b0);
		hold_case(32'h00, 1'b0, 1'b1);
		hold_case(32'h40, 1'b1, 1'b1);
		hold_case(32'h20, 1'b0, 1'b0);
		edge_case(1'b0, 1'b1, 1'b0);
		edge_case(1'b0, 1'b0, 1'b1);
		edge_case(1'b1, 1'b1, 1'b1);
		edge_case(1'b1, 1'b0, 1'b0);
		wr(8'h48, 32'h0);
		t_coast();
		t_ext();
		t_rereset();
		sleep_case(32'h04, 1'b1, 2'h2);
		sleep_case(32'h06, 1'b1, 2'h1);
		sleep_case(32'h06, 1'b0, 2'h0);
		sleep_case(32'h00, 1'b0, 2'h2);
		results();
	end
endmodule

/* sync_coast_pkg.sv */
// constants for the sync input, hold and pixel clock control block
package sync_coast_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_HSYNC  = 6'h12;
	localparam logic [5:0] IDX_COAST  = 6'h18;
	localparam logic [5:0] IDX_SLICE  = 6'h1d;
	localparam logic [5:0] IDX_SLEEP  = 6'h26;
	localparam logic [5:0] IDX_CLKCFG = 6'h30;
	localparam logic [5:0] IDX_THRESH = 6'h31;
	localparam logic [5:0] IDX_STATUS = 6'h32;
	// field positions
	localparam int HS_LSB     = 4;
	localparam int COAST_LSB  = 5;
	localparam int SLICE_LSB  = 0;
	localparam int SLEEP_LSB  = 1;
	localparam int EXT_BIT    = 0;
	localparam int DIV_LSB    = 8;
	localparam int DIV_W      = 8;
	localparam int THR_W      = 6;
	// reset values
	localparam logic [1:0]       HS_RST    = 2'h0;
	localparam logic [1:0]       COAST_RST = 2'h1;
	localparam logic [1:0]       SLICE_RST = 2'h0;
	localparam logic [1:0]       SLEEP_RST = 2'h0;
	localparam logic [DIV_W-1:0] DIV_RST   = 8'h04;
	// threshold in millivolts, code is millivolts over step
	localparam int THR_STEP_MV = 10;
	localparam int THR_MIN_MV  = 10;
	localparam int THR_MAX_MV  = 330;
	localparam int THR_DEF_MV  = 150;
	localparam logic [THR_W-1:0] THR_MIN = THR_W'(THR_MIN_MV / THR_STEP_MV);
	localparam logic [THR_W-1:0] THR_MAX = THR_W'(THR_MAX_MV / THR_STEP_MV);
	localparam logic [THR_W-1:0] THR_DEF = THR_W'(THR_DEF_MV / THR_STEP_MV);
	// slicer output choices
	localparam logic [1:0] SEL_RAW_SOG = 2'h0;
	localparam logic [1:0] SEL_RAW_HS  = 2'h1;
	localparam logic [1:0] SEL_REGEN   = 2'h2;
	localparam logic [1:0] SEL_FILT    = 2'h3;
	// sync glitch filter length in samples
	localparam int FILT_LEN = 3;
	localparam int PER_W    = 20;
endpackage

/* sync_src_model.sv */
// video source model: line sync pulses that the source may stop
`timescale 1ns/1ps
module sync_src_model #(
	parameter int LINE = 40
) (
	input  wire logic clk_i,
	input  wire logic run_i,
	input  wire logic idle_i,
	output logic      hsync_o
);
	int cnt = 0;

	// a stopped source parks the line at a level the bench chooses
	always @(posedge clk_i)
	begin
		cnt     <= (cnt == LINE - 1) ? 0 : cnt + 1;
		hsync_o <= run_i ? (cnt < 4) : idle_i;
	end
endmodule
